// ==== tsr_pkg.sv ====
// Package: register map, field layout and reset values of the trigger source router bank
package tsr_pkg;
	localparam int unsigned NUM_ROUTES = 9;
	localparam int unsigned SEL_W = 8;
	localparam int unsigned LOCK_BIT = 31;
	localparam int unsigned SEL_LSB = 0;
	localparam logic [11:0] OFF_TIMER2 = 12'h064;
	localparam logic [11:0] OFF_TIMER3 = 12'h068;
	localparam logic [11:0] OFF_TIMER4 = 12'h06C;
	localparam logic [11:0] OFF_TIMER7 = 12'h070;
	localparam logic [11:0] OFF_TIMER22 = 12'h074;
	localparam logic [11:0] OFF_TIMER23 = 12'h078;
	localparam logic [11:0] OFF_TIMER30 = 12'h07C;
	localparam logic [11:0] OFF_TIMER31 = 12'h080;
	localparam logic [11:0] OFF_AUX = 12'h084;
	localparam logic [7:0] RST_TIMER2 = 8'h30;
	localparam logic [7:0] RST_TIMER3 = 8'h36;
	localparam logic [7:0] RST_TIMER4 = 8'h3C;
	localparam logic [7:0] RST_TIMER7 = 8'h52;
	localparam logic [7:0] RST_TIMER22 = 8'h69;
	localparam logic [7:0] RST_TIMER23 = 8'h6F;
	localparam logic [7:0] RST_TIMER30 = 8'h75;
	localparam logic [7:0] RST_TIMER31 = 8'h7B;
	localparam logic [7:0] RST_AUX = 8'h00;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	typedef enum logic [1:0] {
		TSR_IDLE = 2'b00,
		TSR_WRITE = 2'b01,
		TSR_READ = 2'b10
	} tsr_phase_type;
endpackage

// ==== tsr_route_mux.sv ====
// Single routing multiplexer: selection index into the trigger source vector
`timescale 1ns/1ps
`default_nettype none
module tsr_route_mux #(
	parameter int unsigned NUM_SRC = 256,
	parameter int unsigned SEL_W = 8
) (
	input  wire logic [NUM_SRC-1:0] sources,
	input  wire logic [SEL_W-1:0]   select,
	output logic                    route_out
);
	always_comb begin
		route_out = 1'b0;
		if (32'(select) < NUM_SRC) begin
			route_out = sources[select];
		end
	end
endmodule
`default_nettype wire

// ==== tsr_trigger_router.sv ====
// Top: AHB-Lite slave with nine lockable trigger routing registers and their multiplexers
//
// Functional notes
// - Bit 31 is a lock bit, set by writing one, never cleared by writing.
// - Lock stays set until system reset, which clears it.
// - Writes take effect while unlocked and are ignored while locked.
// - Bits 7:0 select the trigger source driving the register's output.
// - Offset 0x64 drives timer2 external trigger, selection resets to 0x30.
// - Offset 0x68 drives timer3 external trigger, selection resets to 0x36.
// - Offset 0x6C drives timer4 external trigger, selection resets to 0x3C.
// - Offset 0x70 drives timer7 external trigger, selection resets to 0x52.
// - Offset 0x74 drives timer22 external trigger, selection resets to 0x69.
// - Offset 0x78 drives timer23 external trigger, selection resets to 0x6F.
// - Offset 0x7C drives timer30 external trigger, selection resets to 0x75.
// - Offset 0x80 drives timer31 external trigger, selection resets to 0x7B.
// - Offset 0x84 drives auxiliary output trigger, whole register resets to zero.
`timescale 1ns/1ps
`default_nettype none
module tsr_trigger_router #(
	parameter int unsigned NUM_SRC = 256
) (
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               hsel,
	input  wire logic [11:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic [31:0]             hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	input  wire logic [NUM_SRC-1:0] trigger_sources,
	output logic                    timer2_external_trigger_in,
	output logic                    timer3_external_trigger_in,
	output logic                    timer4_external_trigger_in,
	output logic                    timer7_external_trigger_in,
	output logic                    timer22_external_trigger_in,
	output logic                    timer23_external_trigger_in,
	output logic                    timer30_external_trigger_in,
	output logic                    timer31_external_trigger_in,
	output logic                    auxiliary_output_trigger
);
	localparam int unsigned N = tsr_pkg::NUM_ROUTES;
	localparam int unsigned SW = tsr_pkg::SEL_W;

	typedef struct packed {
		tsr_pkg::tsr_phase_type phase;
		logic [3:0]             index;
		logic                   hit;
		logic [N-1:0]           lock;
		logic [N-1:0][SW-1:0]   select;
		logic [31:0]            rdata;
	} tsr_state_type;

	localparam logic [N-1:0][11:0] OFFSETS = {
		tsr_pkg::OFF_AUX, tsr_pkg::OFF_TIMER31, tsr_pkg::OFF_TIMER30,
		tsr_pkg::OFF_TIMER23, tsr_pkg::OFF_TIMER22, tsr_pkg::OFF_TIMER7,
		tsr_pkg::OFF_TIMER4, tsr_pkg::OFF_TIMER3, tsr_pkg::OFF_TIMER2
	};
	localparam logic [N-1:0][SW-1:0] RESETS = {
		tsr_pkg::RST_AUX, tsr_pkg::RST_TIMER31, tsr_pkg::RST_TIMER30,
		tsr_pkg::RST_TIMER23, tsr_pkg::RST_TIMER22, tsr_pkg::RST_TIMER7,
		tsr_pkg::RST_TIMER4, tsr_pkg::RST_TIMER3, tsr_pkg::RST_TIMER2
	};

	tsr_state_type s_q;
	tsr_state_type s_d;
	logic          addr_hit;
	logic [3:0]    addr_index;
	logic          take;
	logic [N-1:0]  routes;

	// Decode the address phase against the register map
	always_comb begin
		addr_hit = 1'b0;
		addr_index = 4'h0;
		for (int i = 0; i < N; i++) begin
			if (haddr == OFFSETS[i]) begin
				addr_hit = 1'b1;
				addr_index = 4'(i);
			end
		end
	end

	assign take = hsel && hready && (htrans == tsr_pkg::HTRANS_NONSEQ ||
		htrans == tsr_pkg::HTRANS_SEQ);

	always_comb begin
		s_d = s_q;
		s_d.phase = tsr_pkg::TSR_IDLE;
		// Data phase of a write: lock set by one, selection only while unlocked
		if (s_q.phase == tsr_pkg::TSR_WRITE && s_q.hit) begin
			if (!s_q.lock[s_q.index]) begin
				s_d.select[s_q.index] = hwdata[tsr_pkg::SEL_LSB +: SW];
				s_d.lock[s_q.index] = hwdata[tsr_pkg::LOCK_BIT];
			end
		end
		if (take) begin
			s_d.phase = hwrite ? tsr_pkg::TSR_WRITE : tsr_pkg::TSR_READ;
			s_d.hit = addr_hit;
			s_d.index = addr_index;
			s_d.rdata = 32'h0000_0000;
			// Reads see the state after any write finishing in this cycle
			if (!hwrite && addr_hit) begin
				s_d.rdata[tsr_pkg::LOCK_BIT] = s_d.lock[addr_index];
				s_d.rdata[tsr_pkg::SEL_LSB +: SW] = s_d.select[addr_index];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q.phase <= tsr_pkg::TSR_IDLE;
			s_q.index <= 4'h0;
			s_q.hit <= 1'b0;
			s_q.lock <= '0;
			s_q.select <= RESETS;
			s_q.rdata <= 32'h0000_0000;
		end else begin
			s_q <= s_d;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_q.rdata;

	// One multiplexer per destination
	for (genvar g = 0; g < N; g++) begin : g_route
		tsr_route_mux #(
			.NUM_SRC(NUM_SRC),
			.SEL_W  (SW)
		) u_mux (
			.sources  (trigger_sources),
			.select   (s_q.select[g]),
			.route_out(routes[g])
		);
	end

	assign timer2_external_trigger_in = routes[0];
	assign timer3_external_trigger_in = routes[1];
	assign timer4_external_trigger_in = routes[2];
	assign timer7_external_trigger_in = routes[3];
	assign timer22_external_trigger_in = routes[4];
	assign timer23_external_trigger_in = routes[5];
	assign timer30_external_trigger_in = routes[6];
	assign timer31_external_trigger_in = routes[7];
	assign auxiliary_output_trigger = routes[8];

	// Assertions
	a_lock_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(s_q.lock[0]) |-> s_q.lock[0] [*8])
		else $error("lock bit cleared without reset");

	a_lock_never_falls: assert property (@(posedge hclk) disable iff (!hresetn)
		s_q.lock != 0 |=> (s_q.lock & $past(s_q.lock)) == $past(s_q.lock))
		else $error("a set lock bit fell");

	a_locked_select_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		s_q.lock[1] |=> s_q.select[1] == $past(s_q.select[1]))
		else $error("locked selection changed");

	a_unlocked_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_q.phase == tsr_pkg::TSR_WRITE && s_q.hit && s_q.index == 4'h0
		&& !s_q.lock[0]) |=> s_q.select[0] == $past(hwdata[7:0]))
		else $error("unlocked write did not take effect");

	a_lock_set: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_q.phase == tsr_pkg::TSR_WRITE && s_q.hit && s_q.index == 4'h2
		&& !s_q.lock[2] && hwdata[31]) |=> s_q.lock[2])
		else $error("writing one did not set lock");

	a_mux_route: assert property (@(posedge hclk) disable iff (!hresetn)
		32'(s_q.select[0]) < NUM_SRC |->
		timer2_external_trigger_in == trigger_sources[s_q.select[0]])
		else $error("timer2 route does not follow selection");

	a_mux_aux: assert property (@(posedge hclk) disable iff (!hresetn)
		32'(s_q.select[8]) < NUM_SRC |->
		auxiliary_output_trigger == trigger_sources[s_q.select[8]])
		else $error("auxiliary route does not follow selection");

	a_read_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
		s_q.phase == tsr_pkg::TSR_READ |-> hrdata[30:8] == 23'h0)
		else $error("reserved bits read non-zero");

	a_read_value: assert property (@(posedge hclk) disable iff (!hresetn)
		(take && !hwrite && addr_hit && haddr == tsr_pkg::OFF_TIMER3
		&& s_q.phase != tsr_pkg::TSR_WRITE)
		|=> hrdata == {s_q.lock[1], 23'h0, s_q.select[1]})
		else $error("read data does not match register");

	a_route_timer3: assert property (@(posedge hclk) disable iff (!hresetn)
		32'(s_q.select[1]) < NUM_SRC |->
		timer3_external_trigger_in == trigger_sources[s_q.select[1]])
		else $error("timer3 route does not follow selection");

	a_route_timer4: assert property (@(posedge hclk) disable iff (!hresetn)
		32'(s_q.select[2]) < NUM_SRC |->
		timer4_external_trigger_in == trigger_sources[s_q.select[2]])
		else $error("timer4 route does not follow selection");

	a_route_timer7: assert property (@(posedge hclk) disable iff (!hresetn)
		32'(s_q.select[3]) < NUM_SRC |->
		timer7_external_trigger_in == trigger_sources[s_q.select[3]])
		else $error("timer7 route does not follow selection");

	a_route_timer22: assert property (@(posedge hclk) disable iff (!hresetn)
		32'(s_q.select[4]) < NUM_SRC |->
		timer22_external_trigger_in == trigger_sources[s_q.select[4]])
		else $error("timer22 route does not follow selection");

	a_route_timer23: assert property (@(posedge hclk) disable iff (!hresetn)
		32'(s_q.select[5]) < NUM_SRC |->
		timer23_external_trigger_in == trigger_sources[s_q.select[5]])
		else $error("timer23 route does not follow selection");

	a_route_timer30: assert property (@(posedge hclk) disable iff (!hresetn)
		32'(s_q.select[6]) < NUM_SRC |->
		timer30_external_trigger_in == trigger_sources[s_q.select[6]])
		else $error("timer30 route does not follow selection");

	a_route_timer31: assert property (@(posedge hclk) disable iff (!hresetn)
		32'(s_q.select[7]) < NUM_SRC |->
		timer31_external_trigger_in == trigger_sources[s_q.select[7]])
		else $error("timer31 route does not follow selection");

	a_locked_hold_0: assert property (@(posedge hclk) disable iff (!hresetn)
		s_q.lock[0] |=> s_q.select[0] == $past(s_q.select[0]))
		else $error("locked selection 0 changed");

	a_locked_hold_2: assert property (@(posedge hclk) disable iff (!hresetn)
		s_q.lock[2] |=> s_q.select[2] == $past(s_q.select[2]))
		else $error("locked selection 2 changed");

	a_locked_hold_3: assert property (@(posedge hclk) disable iff (!hresetn)
		s_q.lock[3] |=> s_q.select[3] == $past(s_q.select[3]))
		else $error("locked selection 3 changed");

	a_locked_hold_4: assert property (@(posedge hclk) disable iff (!hresetn)
		s_q.lock[4] |=> s_q.select[4] == $past(s_q.select[4]))
		else $error("locked selection 4 changed");

	a_locked_hold_5: assert property (@(posedge hclk) disable iff (!hresetn)
		s_q.lock[5] |=> s_q.select[5] == $past(s_q.select[5]))
		else $error("locked selection 5 changed");

	a_locked_hold_6: assert property (@(posedge hclk) disable iff (!hresetn)
		s_q.lock[6] |=> s_q.select[6] == $past(s_q.select[6]))
		else $error("locked selection 6 changed");

	a_locked_hold_7: assert property (@(posedge hclk) disable iff (!hresetn)
		s_q.lock[7] |=> s_q.select[7] == $past(s_q.select[7]))
		else $error("locked selection 7 changed");

	a_locked_hold_8: assert property (@(posedge hclk) disable iff (!hresetn)
		s_q.lock[8] |=> s_q.select[8] == $past(s_q.select[8]))
		else $error("locked selection 8 changed");

	a_write_select: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_q.phase == tsr_pkg::TSR_WRITE && s_q.hit && !s_q.lock[s_q.index])
		|=> s_q.select[$past(s_q.index)] == $past(hwdata[7:0]))
		else $error("unlocked write lost its selection");

	a_write_lock_set: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_q.phase == tsr_pkg::TSR_WRITE && s_q.hit && !s_q.lock[s_q.index]
		&& hwdata[31]) |=> s_q.lock[$past(s_q.index)])
		else $error("writing one left the lock clear");

	a_write_zero_keeps: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_q.phase == tsr_pkg::TSR_WRITE && s_q.hit && !s_q.lock[s_q.index]
		&& !hwdata[31]) |=> !s_q.lock[$past(s_q.index)])
		else $error("writing zero set the lock");

	a_locked_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_q.phase == tsr_pkg::TSR_WRITE && s_q.hit && s_q.lock[s_q.index])
		|=> $stable(s_q.select) && $stable(s_q.lock))
		else $error("write to a locked register changed state");

	a_unmapped_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_q.phase == tsr_pkg::TSR_WRITE && !s_q.hit)
		|=> $stable(s_q.select) && $stable(s_q.lock))
		else $error("unmapped write changed state");

	a_read_mapped: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_q.phase == tsr_pkg::TSR_READ && s_q.hit) |->
		hrdata == {s_q.lock[s_q.index], 23'h0, s_q.select[s_q.index]})
		else $error("read data does not match addressed register");

	a_read_unmapped: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_q.phase == tsr_pkg::TSR_READ && !s_q.hit) |-> hrdata == 32'h0000_0000)
		else $error("unmapped read returned data");

	a_reset_values: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) |-> s_q.lock == '0 && s_q.select == RESETS
		&& hrdata == 32'h0000_0000)
		else $error("state after reset differs from reset values");

	a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
		hreadyout && !hresp)
		else $error("bus answer is not zero-wait OKAY");

	a_reset_route_t2: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) && 32'(tsr_pkg::RST_TIMER2) < NUM_SRC |->
		timer2_external_trigger_in == trigger_sources[tsr_pkg::RST_TIMER2])
		else $error("timer2 route after reset uses wrong source");

	a_reset_route_t3: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) && 32'(tsr_pkg::RST_TIMER3) < NUM_SRC |->
		timer3_external_trigger_in == trigger_sources[tsr_pkg::RST_TIMER3])
		else $error("timer3 route after reset uses wrong source");

	a_reset_route_t4: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) && 32'(tsr_pkg::RST_TIMER4) < NUM_SRC |->
		timer4_external_trigger_in == trigger_sources[tsr_pkg::RST_TIMER4])
		else $error("timer4 route after reset uses wrong source");

	a_reset_route_t7: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) && 32'(tsr_pkg::RST_TIMER7) < NUM_SRC |->
		timer7_external_trigger_in == trigger_sources[tsr_pkg::RST_TIMER7])
		else $error("timer7 route after reset uses wrong source");

	a_reset_route_t22: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) && 32'(tsr_pkg::RST_TIMER22) < NUM_SRC |->
		timer22_external_trigger_in == trigger_sources[tsr_pkg::RST_TIMER22])
		else $error("timer22 route after reset uses wrong source");

	a_reset_route_t23: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) && 32'(tsr_pkg::RST_TIMER23) < NUM_SRC |->
		timer23_external_trigger_in == trigger_sources[tsr_pkg::RST_TIMER23])
		else $error("timer23 route after reset uses wrong source");

	a_reset_route_t30: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) && 32'(tsr_pkg::RST_TIMER30) < NUM_SRC |->
		timer30_external_trigger_in == trigger_sources[tsr_pkg::RST_TIMER30])
		else $error("timer30 route after reset uses wrong source");

	a_reset_route_t31: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) && 32'(tsr_pkg::RST_TIMER31) < NUM_SRC |->
		timer31_external_trigger_in == trigger_sources[tsr_pkg::RST_TIMER31])
		else $error("timer31 route after reset uses wrong source");

	a_reset_route_aux: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) && 32'(tsr_pkg::RST_AUX) < NUM_SRC |->
		auxiliary_output_trigger == trigger_sources[tsr_pkg::RST_AUX])
		else $error("auxiliary route after reset uses wrong source");
endmodule
`default_nettype wire

// ==== tsr_source_model.sv ====
// Trigger source side: drives a known pattern, inverted on demand
`timescale 1ns/1ps
`default_nettype none
module tsr_source_model #(
	parameter logic [255:0] PAT = {8{32'hA5C3_1E69}}
) (
	input  wire logic         flip,
	output logic [255:0]      trigger_sources
);
	assign trigger_sources = flip ? ~PAT : PAT;
endmodule
`default_nettype wire

// ==== tsr_trigger_router_tb.sv ====
// Self-checking bench for the trigger source router bank
`timescale 1ns/1ps
`default_nettype none
module tsr_trigger_router_tb;
	localparam logic [255:0] PAT = {8{32'hA5C3_1E69}};
	logic              hclk;
	logic              hresetn;
	logic              hsel;
	logic [11:0]       haddr;
	logic [1:0]        htrans;
	logic              hwrite;
	logic [2:0]        hsize;
	logic [31:0]       hwdata;
	logic              flip;
	logic [31:0]       rd;
	wire logic [31:0]  hrdata;
	wire logic         hreadyout;
	wire logic         hresp;
	wire logic [255:0] srcs;
	wire logic [8:0]   routes;
	int                err_count;
	int                total_checks;
	logic [11:0]       offs [9];
	logic [7:0]        rsts [9];
	tsr_source_model tsr_source_model_inst (.flip(flip), .trigger_sources(srcs));
	tsr_trigger_router tsr_trigger_router_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.trigger_sources(srcs), .timer2_external_trigger_in(routes[0]),
		.timer3_external_trigger_in(routes[1]), .timer4_external_trigger_in(routes[2]),
		.timer7_external_trigger_in(routes[3]), .timer22_external_trigger_in(routes[4]),
		.timer23_external_trigger_in(routes[5]), .timer30_external_trigger_in(routes[6]),
		.timer31_external_trigger_in(routes[7]), .auxiliary_output_trigger(routes[8]));
	task automatic check_word(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic check_bit(input logic g, input logic e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Single whole-word transfer; read data lands in rd
	task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		haddr  <= a;
		hwrite <= wr;
		htrans <= tsr_pkg::HTRANS_NONSEQ;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		check_bit(hresp, 1'b0);
	endtask
	task automatic t_reset;
		for (int i = 0; i < 9; i++) begin
			ahb(1'b0, offs[i], 32'h0);
			check_word(rd, {24'h0, rsts[i]});
			check_bit(routes[i], PAT[rsts[i]]);
		end
		$display("reset values done");
	endtask
	task automatic t_select;
		logic [7:0] s;
		for (int i = 0; i < 9; i++) begin
			s = 8'hC7 - 8'(i * 19);
			ahb(1'b1, offs[i], {24'h0, s});
			#1 check_bit(routes[i], PAT[s]);
			ahb(1'b0, offs[i], 32'h0);
			check_word(rd, {24'h0, s});
		end
		flip <= 1'b1;
		@(posedge hclk);
		#1 check_bit(routes[8], ~PAT[8'hC7 - 8'(8 * 19)]);
		@(posedge hclk);
		flip <= 1'b0;
		$display("selection done");
	endtask
	task automatic t_lock;
		ahb(1'b1, offs[0], 32'h8000_00A1);
		ahb(1'b0, offs[0], 32'h0);
		check_word(rd, 32'h8000_00A1);
		ahb(1'b1, offs[0], 32'h0000_0011);
		ahb(1'b0, offs[0], 32'h0);
		check_word(rd, 32'h8000_00A1);
		#1 check_bit(routes[0], PAT[8'hA1]);
		ahb(1'b1, offs[1], 32'h0000_0022);
		ahb(1'b0, offs[1], 32'h0);
		check_word(rd, 32'h0000_0022);
		ahb(1'b1, 12'h088, 32'hFFFF_FFFF);
		ahb(1'b0, 12'h088, 32'h0);
		check_word(rd, 32'h0);
		$display("lock and unmapped done");
	endtask
	task automatic t_lock_all;
		logic [31:0] v;
		for (int i = 1; i < 9; i++) begin
			v = 32'h8000_0010 + 32'(i);
			ahb(1'b1, offs[i], v);
			ahb(1'b1, offs[i], 32'h0000_00FF);
			ahb(1'b0, offs[i], 32'h0);
			check_word(rd, v);
			check_bit(routes[i], PAT[v[7:0]]);
		end
		$display("lock all done");
	endtask
	task automatic t_rst;
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, offs[0], 32'h0);
		check_word(rd, {24'h0, tsr_pkg::RST_TIMER2});
		for (int i = 1; i < 9; i++) begin
			ahb(1'b0, offs[i], 32'h0);
			check_word(rd, {24'h0, rsts[i]});
		end
		ahb(1'b1, offs[0], 32'h0000_0044);
		ahb(1'b0, offs[0], 32'h0);
		check_word(rd, 32'h0000_0044);
		$display("second reset done");
	endtask
	task automatic results;
		$display("checks=%0d mismatches=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	initial begin
		#20000;
		err_count++;
		results();
	end
	initial begin
		offs = '{tsr_pkg::OFF_TIMER2, tsr_pkg::OFF_TIMER3, tsr_pkg::OFF_TIMER4,
			tsr_pkg::OFF_TIMER7, tsr_pkg::OFF_TIMER22, tsr_pkg::OFF_TIMER23,
			tsr_pkg::OFF_TIMER30, tsr_pkg::OFF_TIMER31, tsr_pkg::OFF_AUX};
		rsts = '{tsr_pkg::RST_TIMER2, tsr_pkg::RST_TIMER3, tsr_pkg::RST_TIMER4,
			tsr_pkg::RST_TIMER7, tsr_pkg::RST_TIMER22, tsr_pkg::RST_TIMER23,
			tsr_pkg::RST_TIMER30, tsr_pkg::RST_TIMER31, tsr_pkg::RST_AUX};
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 12'h000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = tsr_pkg::HSIZE_WORD;
		hwdata = 32'h0;
		flip = 1'b0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_select();
		t_lock();
		t_lock_all();
		t_rst();
		results();
	end
endmodule
`default_nettype wire
